// ==== verilog/isa_window_pkg.sv ====
// Constants, field positions and carrier types for the ISA window bridge.
`default_nettype none
package isa_window_pkg;
  // Microcontroller address map.
  localparam logic [7:0]  IO_WINDOW_PAGE      = 8'h40;
  localparam logic [3:0]  MEM_WINDOW_NIBBLE   = 4'h5;
  localparam logic [15:0] REG_IO_UPPER_ADDR   = 16'h7f71;
  localparam logic [15:0] REG_MEM_UPPER_ADDR  = 16'h7f72;
  localparam logic [7:0]  IO_UPPER_RESET      = 8'h00;
  localparam logic [7:0]  MEM_UPPER_RESET     = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ       = 8'h00;
  // DMA runtime registers in ISA I/O space.
  localparam logic [11:0] DMA_REG_PAGE        = 12'h000;
  localparam logic [3:0]  OFF_LAST_CHANNEL    = 4'h7;
  localparam logic [3:0]  OFF_STATUS_COMMAND  = 4'h8;
  localparam logic [3:0]  OFF_SOFT_REQUEST    = 4'h9;
  localparam logic [3:0]  OFF_SINGLE_MASK     = 4'ha;
  localparam logic [3:0]  OFF_CHANNEL_MODE    = 4'hb;
  localparam logic [3:0]  OFF_PTR_CLEAR_TEMP  = 4'hc;
  localparam logic [3:0]  OFF_MASTER_CLEAR    = 4'hd;
  localparam logic [3:0]  OFF_CLEAR_MASKS     = 4'he;
  localparam logic [3:0]  OFF_WRITE_MASKS     = 4'hf;
  localparam int          SET_CLEAR_BIT       = 2;
  localparam logic [3:0]  ALL_MASKED          = 4'hf;
  localparam logic [3:0]  NONE_MASKED         = 4'h0;
  localparam logic [7:0]  REG8_RESET          = 8'h00;
  localparam logic [15:0] REG16_RESET         = 16'h0000;
  // Layout of a 16-bit DMA address.
  localparam int          SELECT_BIT          = 15;
  localparam int          PACKET_HI           = 14;
  localparam int          PACKET_LO           = 10;
  localparam int          OFFSET_HI           = 9;
  localparam int          PAGE_INDEX_LO       = 7;
  localparam logic [1:0]  COUNT_HIGH_KEEP     = 2'h3;
  localparam logic [4:0]  EXT_UPPER_ZERO      = 5'h00;
  localparam logic [1:0]  FIRST_IO_CHANNEL    = 2'h2;
  // Packet buffer paging.
  localparam int          CHANNELS            = 4;
  localparam int          PACKETS             = 32;
  localparam int          PAGES_PER_PACKET    = 10;
  localparam logic [4:0]  PAGE_RESET          = 5'h00;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } mcu_req_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic        ior;
    logic        iow;
    logic        memr;
    logic        memw;
  } isa_cycle_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  packet;
    logic [10:0] pointer;
    logic [11:0] phys_addr;
  } buf_access_t;

  typedef struct packed {
    logic [4:0] packet;
    logic [3:0] index;
    logic [4:0] page;
    logic       wr;
  } page_map_t;
endpackage : isa_window_pkg
`default_nettype wire

// ==== verilog/isa_window_dma_address_map.sv ====
// ISA window bridge, DMA runtime registers and DMA address translation.
// Contract
// - I/O window address is upper-address byte then window offset byte.
// - Memory window address is upper-address byte then 12-bit offset.
// - DMA addresses 0x8000-0xFFFF are 32 packet windows of 1k each.
// - DMA addresses 0x0000-0x7FFF go to 32K of external ISA RAM.
// - Packet number and offset map through eight of ten 128-byte page entries.
// - Every channel holds its own packet number and offset.
// - Sixteen DMA registers sit at ISA I/O 0x00-0x0F.
// - Channel n address at offset 2n, count at 2n+1, byte wide.
// - Offsets 0x8 to 0xF decode to status, command, request, mask, mode, temporary and clear functions.
// - DMA address bit 15 picks internal buffer or external memory.
// - Internal: packet number bits 14:10, offset 9:0; else pass through.
// - External-memory I/O capability only on channels 2 and 3.
// - External DMA zeroes ISA bits 19:15; internal zeroes bit ten.
// - One DMA transfer is at most 1024 bytes.
// - Memory window reaches 1 Mbyte regardless of the DMA 32K limit.
// - Byte pointer low selects low byte, high selects high byte.
`default_nettype none
module isa_window_dma_address_map (
  // Clock and reset.
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  // Microcontroller access port.
  input  wire isa_window_pkg::mcu_req_t    mcu_req,
  input  wire logic                        bus_grant_acknowledge,
  output logic [7:0]                       mcu_rdata,
  output logic                             mcu_rdata_valid,
  // ISA bus side.
  input  wire logic [7:0]                  isa_rdata,
  input  wire logic [3:0]                  dreq_pin,
  output isa_window_pkg::isa_cycle_t       isa,
  // DMA engine side.
  input  wire logic                        dma_cycle,
  input  wire logic [1:0]                  dma_channel,
  output isa_window_pkg::buf_access_t      buf_access,
  output logic                             dma_ext_mem,
  output logic                             dma_io_enable,
  output logic [7:0]                       dma_command,
  output logic [3:0]                       dma_channel_mask,
  output logic [3:0]                       dma_soft_request,
  output logic                             byte_pointer,
  // Page map loaded by the memory manager.
  input  wire isa_window_pkg::page_map_t   page_map
);

  logic [7:0]  io_window_upper_address;
  logic [7:0]  memory_window_upper_address;
  logic [15:0] ch_addr [isa_window_pkg::CHANNELS];
  logic [15:0] ch_count [isa_window_pkg::CHANNELS];
  logic [7:0]  ch_mode [isa_window_pkg::CHANNELS];
  logic [4:0]  page_table [isa_window_pkg::PACKETS]
                          [isa_window_pkg::PAGES_PER_PACKET];
  logic [3:0]  tc_flag;
  logic [3:0]  dreq_s1;
  logic [3:0]  dreq_s2;
  logic [3:0]  dreq_s3;
  logic [3:0]  dreq_level;
  logic [7:0]  temp_reg;
  logic        rd_pend;
  logic        rd_internal;
  logic [7:0]  rd_hold;
  logic [7:0]  next_rdata;
  logic        io_hit;
  logic        mem_hit;
  logic        dma_reg_hit;
  logic        wr_ok;
  logic        chan_access;
  logic        ptr_clear;
  logic        status_read;
  logic [15:0] io_addr;
  logic [3:0]  reg_off;
  logic [3:0]  tc_event;
  logic [15:0] sel_addr;
  logic [3:0]  page_index;

  // Window decode of the microcontroller address.
  always_comb
  begin
    io_hit      = mcu_req.addr[15:8] == isa_window_pkg::IO_WINDOW_PAGE;
    mem_hit     = mcu_req.addr[15:12] == isa_window_pkg::MEM_WINDOW_NIBBLE;
    io_addr     = {io_window_upper_address, mcu_req.addr[7:0]};
    reg_off     = io_addr[3:0];
    dma_reg_hit = io_hit && io_addr[15:4] == isa_window_pkg::DMA_REG_PAGE;
    // Writes while the DMA owns the bus would race its own updates.
    wr_ok       = mcu_req.wr && !bus_grant_acknowledge;
    chan_access = dma_reg_hit && reg_off <= isa_window_pkg::OFF_LAST_CHANNEL
                  && (mcu_req.rd || wr_ok);
    ptr_clear   = dma_reg_hit && wr_ok
                  && (reg_off == isa_window_pkg::OFF_PTR_CLEAR_TEMP
                  || reg_off == isa_window_pkg::OFF_MASTER_CLEAR);
    status_read = dma_reg_hit && mcu_req.rd
                  && reg_off == isa_window_pkg::OFF_STATUS_COMMAND;
    sel_addr    = ch_addr[dma_channel];
    page_index  = {1'b0, sel_addr[isa_window_pkg::OFFSET_HI:
                                  isa_window_pkg::PAGE_INDEX_LO]};
  end

  // Base registers of the two microcontroller windows.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      io_window_upper_address     <= isa_window_pkg::IO_UPPER_RESET;
      memory_window_upper_address <= isa_window_pkg::MEM_UPPER_RESET;
    end
    else if (mcu_req.wr)
    begin
      if (mcu_req.addr == isa_window_pkg::REG_IO_UPPER_ADDR)
        io_window_upper_address <= mcu_req.wdata;
      if (mcu_req.addr == isa_window_pkg::REG_MEM_UPPER_ADDR)
        memory_window_upper_address <= mcu_req.wdata;
    end
  end

  // Byte pointer flip-flop.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      byte_pointer <= 1'b0;
    else if (ptr_clear)
      byte_pointer <= 1'b0;
    else if (chan_access)
      byte_pointer <= !byte_pointer;
  end

  // Per-channel address and count registers, stepped by DMA cycles.
  for (genvar n = 0; n < isa_window_pkg::CHANNELS; n++)
  begin : g_chan
    logic addr_hit;
    logic count_hit;
    logic step;
    assign addr_hit  = dma_reg_hit && wr_ok && reg_off == 4'(2 * n);
    assign count_hit = dma_reg_hit && wr_ok && reg_off == 4'(2 * n + 1);
    assign step      = dma_cycle && bus_grant_acknowledge
                       && dma_channel == 2'(n);

    always_ff @(posedge clock or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        ch_addr[n]  <= isa_window_pkg::REG16_RESET;
        ch_count[n] <= isa_window_pkg::REG16_RESET;
      end
      else if (addr_hit)
      begin
        if (byte_pointer)
          ch_addr[n][15:8] <= mcu_req.wdata;
        else
          ch_addr[n][7:0] <= mcu_req.wdata;
      end
      else if (count_hit)
      begin
        // Counts above 1023 would let one transfer pass 1024 bytes.
        if (byte_pointer)
          ch_count[n][15:8] <= {6'h00, mcu_req.wdata[1:0]
                                & isa_window_pkg::COUNT_HIGH_KEEP};
        else
          ch_count[n][7:0] <= mcu_req.wdata;
      end
      else if (step)
      begin
        // The offset wraps inside its 1k window so a packet never spills.
        ch_addr[n][9:0] <= ch_addr[n][9:0] + 10'h001;
        ch_count[n]     <= ch_count[n] - 16'h0001;
      end
    end

    assign tc_event[n] = step && ch_count[n] == isa_window_pkg::REG16_RESET;
  end

  // Mode, command, request, mask and temporary registers.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dma_command      <= isa_window_pkg::REG8_RESET;
      dma_soft_request <= isa_window_pkg::NONE_MASKED;
      dma_channel_mask <= isa_window_pkg::ALL_MASKED;
      temp_reg         <= isa_window_pkg::REG8_RESET;
      for (int c = 0; c < isa_window_pkg::CHANNELS; c++)
        ch_mode[c] <= isa_window_pkg::REG8_RESET;
    end
    else if (dma_reg_hit && wr_ok)
    begin
      case (reg_off)
        isa_window_pkg::OFF_STATUS_COMMAND:
          dma_command <= mcu_req.wdata;
        isa_window_pkg::OFF_SOFT_REQUEST:
          dma_soft_request[mcu_req.wdata[1:0]]
            <= mcu_req.wdata[isa_window_pkg::SET_CLEAR_BIT];
        isa_window_pkg::OFF_SINGLE_MASK:
          dma_channel_mask[mcu_req.wdata[1:0]]
            <= mcu_req.wdata[isa_window_pkg::SET_CLEAR_BIT];
        isa_window_pkg::OFF_CHANNEL_MODE:
          ch_mode[mcu_req.wdata[1:0]] <= mcu_req.wdata;
        isa_window_pkg::OFF_MASTER_CLEAR:
        begin
          dma_command      <= isa_window_pkg::REG8_RESET;
          dma_soft_request <= isa_window_pkg::NONE_MASKED;
          dma_channel_mask <= isa_window_pkg::ALL_MASKED;
          temp_reg         <= isa_window_pkg::REG8_RESET;
        end
        isa_window_pkg::OFF_CLEAR_MASKS:
          dma_channel_mask <= isa_window_pkg::NONE_MASKED;
        isa_window_pkg::OFF_WRITE_MASKS:
          dma_channel_mask <= mcu_req.wdata[3:0];
        default:
          dma_command <= dma_command;
      endcase
    end
  end

  // Request pins cross in through three stages; a change needs two to agree.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dreq_s1    <= 4'h0;
      dreq_s2    <= 4'h0;
      dreq_s3    <= 4'h0;
      dreq_level <= 4'h0;
    end
    else
    begin
      dreq_s1 <= dreq_pin;
      dreq_s2 <= dreq_s1;
      dreq_s3 <= dreq_s2;
      for (int c = 0; c < isa_window_pkg::CHANNELS; c++)
        if (dreq_s2[c] == dreq_s3[c])
          dreq_level[c] <= dreq_s3[c];
    end
  end

  // Terminal count flags clear on a status read; a new count wins.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      tc_flag <= 4'h0;
    else
      tc_flag <= (status_read ? 4'h0 : tc_flag) | tc_event;
  end

  // Read data of the decoded location.
  always_comb
  begin
    next_rdata = isa_window_pkg::UNMAPPED_READ;
    if (mcu_req.addr == isa_window_pkg::REG_IO_UPPER_ADDR)
      next_rdata = io_window_upper_address;
    else if (mcu_req.addr == isa_window_pkg::REG_MEM_UPPER_ADDR)
      next_rdata = memory_window_upper_address;
    else if (dma_reg_hit)
    begin
      case (reg_off)
        isa_window_pkg::OFF_STATUS_COMMAND:
          next_rdata = {dreq_level, tc_flag};
        isa_window_pkg::OFF_PTR_CLEAR_TEMP:
          next_rdata = temp_reg;
        default:
          if (reg_off <= isa_window_pkg::OFF_LAST_CHANNEL)
            next_rdata = reg_off[0]
              ? (byte_pointer ? ch_count[reg_off[2:1]][15:8]
                              : ch_count[reg_off[2:1]][7:0])
              : (byte_pointer ? ch_addr[reg_off[2:1]][15:8]
                              : ch_addr[reg_off[2:1]][7:0]);
      endcase
    end
  end

  // Read answer two edges after the request, once the bus has replied.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_pend         <= 1'b0;
      rd_internal     <= 1'b0;
      rd_hold         <= isa_window_pkg::REG8_RESET;
      mcu_rdata       <= isa_window_pkg::REG8_RESET;
      mcu_rdata_valid <= 1'b0;
    end
    else
    begin
      rd_pend         <= mcu_req.rd;
      rd_internal     <= dma_reg_hit || bus_grant_acknowledge
                         || !(io_hit || mem_hit);
      rd_hold         <= next_rdata;
      mcu_rdata       <= rd_internal ? rd_hold : isa_rdata;
      mcu_rdata_valid <= rd_pend;
    end
  end

  // ISA cycle generation, shared by window cycles and DMA cycles.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      isa <= '0;
    else
    begin
      isa.ior  <= 1'b0;
      isa.iow  <= 1'b0;
      isa.memr <= 1'b0;
      isa.memw <= 1'b0;
      if (bus_grant_acknowledge)
      begin
        // While granted the window drivers stay released.
        if (dma_cycle && !sel_addr[isa_window_pkg::SELECT_BIT])
          isa.addr <= {isa_window_pkg::EXT_UPPER_ZERO,
                       sel_addr[isa_window_pkg::PACKET_HI:0]};
      end
      else if (io_hit && (mcu_req.rd || mcu_req.wr))
      begin
        isa.addr  <= {4'h0, io_addr};
        isa.wdata <= mcu_req.wdata;
        isa.ior   <= mcu_req.rd;
        isa.iow   <= mcu_req.wr;
      end
      else if (mem_hit && (mcu_req.rd || mcu_req.wr))
      begin
        // Full 1 Mbyte reach, unrelated to the DMA external range.
        isa.addr  <= {memory_window_upper_address,
                      mcu_req.addr[11:0]};
        isa.wdata <= mcu_req.wdata;
        isa.memr  <= mcu_req.rd;
        isa.memw  <= mcu_req.wr;
      end
    end
  end

  // Packet page map written by the memory manager.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int p = 0; p < isa_window_pkg::PACKETS; p++)
        for (int i = 0; i < isa_window_pkg::PAGES_PER_PACKET; i++)
          page_table[p][i] <= isa_window_pkg::PAGE_RESET;
    end
    else if (page_map.wr
             && page_map.index < 4'(isa_window_pkg::PAGES_PER_PACKET))
      page_table[page_map.packet][page_map.index] <= page_map.page;
  end

  // DMA address translation of the stepping channel.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      buf_access    <= '0;
      dma_ext_mem   <= 1'b0;
      dma_io_enable <= 1'b0;
    end
    else
    begin
      buf_access.valid <= 1'b0;
      dma_ext_mem      <= 1'b0;
      dma_io_enable    <= 1'b0;
      if (dma_cycle && bus_grant_acknowledge)
      begin
        if (sel_addr[isa_window_pkg::SELECT_BIT])
        begin
          buf_access.valid   <= 1'b1;
          buf_access.packet  <= sel_addr[isa_window_pkg::PACKET_HI:
                                         isa_window_pkg::PACKET_LO];
          buf_access.pointer <= {1'b0,
                                 sel_addr[isa_window_pkg::OFFSET_HI:0]};
          buf_access.phys_addr <= {page_table[sel_addr[
                                   isa_window_pkg::PACKET_HI:
                                   isa_window_pkg::PACKET_LO]][page_index],
                                   sel_addr[6:0]};
        end
        else
        begin
          dma_ext_mem   <= 1'b1;
          dma_io_enable <= dma_channel >= isa_window_pkg::FIRST_IO_CHANNEL;
        end
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_io_access;
    !bus_grant_acknowledge && io_hit && (mcu_req.rd || mcu_req.wr);
  endsequence

  sequence s_internal_cycle;
    dma_cycle && bus_grant_acknowledge && sel_addr[15];
  endsequence

  sequence s_external_cycle;
    dma_cycle && bus_grant_acknowledge && !sel_addr[15];
  endsequence

  a_io_addr_form : assert property (s_io_access |=>
    isa.addr[15:0] == {$past(io_window_upper_address),
                       $past(mcu_req.addr[7:0])} && (isa.ior || isa.iow))
    else $error("I/O window address formed wrongly");

  a_mem_addr_form : assert property (!bus_grant_acknowledge && !io_hit
    && mem_hit && mcu_req.rd |=> isa.memr
    && isa.addr[19:12] == $past(memory_window_upper_address)
    && isa.addr[11:0] == $past(mcu_req.addr[11:0]))
    else $error("Memory window address formed wrongly");

  a_packet_select : assert property (s_internal_cycle |=> buf_access.valid
    && buf_access.packet == $past(sel_addr[14:10]) && !dma_ext_mem)
    else $error("Packet number not taken from address");

  a_ext_route : assert property (s_external_cycle |=> dma_ext_mem
    && !buf_access.valid && isa.addr[19:15] == 5'h00
    && isa.addr[14:0] == $past(sel_addr[14:0]))
    else $error("External DMA address not passed through");

  a_ptr_ten_low : assert property (buf_access.valid |->
    !buf_access.pointer[10])
    else $error("Pointer bit ten driven high");

  a_io_upper_only : assert property (s_external_cycle ##1 dma_io_enable
    |-> $past(dma_channel) >= 2'h2)
    else $error("I/O capability on a low channel");

  a_ptr_toggle : assert property (chan_access && !ptr_clear |=>
    byte_pointer != $past(byte_pointer))
    else $error("Byte pointer failed to toggle");

  a_ptr_clear : assert property (ptr_clear |=> !byte_pointer)
    else $error("Byte pointer not cleared");

  a_tc_set_wins : assert property (status_read && |tc_event |=>
    (tc_flag & $past(tc_event)) == $past(tc_event))
    else $error("Terminal count lost on status read");

  a_read_answer : assert property (mcu_req.rd |-> ##2 mcu_rdata_valid)
    else $error("Read answer missing");

endmodule : isa_window_dma_address_map
`default_nettype wire

// ==== testbench/isa_peripheral_model.sv ====
// ISA-side peripheral and memory model answering the bridge's strobes.
`default_nettype none
module isa_peripheral_model (
  // Clock.
  input  wire logic                       clock,
  // ISA bus.
  input  wire isa_window_pkg::isa_cycle_t isa,
  output logic [7:0]                      isa_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] store [bit [20:0]];
  logic [7:0] last = 8'h00;
  logic       io;
  assign io = isa.ior | isa.iow;
  always @(posedge clock)
  begin
    if (isa.iow | isa.memw)
      store[{io, isa.addr}] = isa.wdata;
    if (isa.ior | isa.memr)
      last = isa_rdata;
  end
  // A released bus shows the inverse of its last value, so a late
  // sample of the bus can never pass for the right byte.
  always @*
  begin
    if (!(isa.ior | isa.memr))
      isa_rdata = ~last;
    else if (store.exists({io, isa.addr}))
      isa_rdata = store[{io, isa.addr}];
    else
      isa_rdata = isa.addr[7:0] ^ 8'h5a;
  end
endmodule : isa_peripheral_model
`default_nettype wire

// ==== testbench/isa_window_dma_address_map_tb_top.sv ====
// Self-checking bench for the ISA window bridge and DMA address map.
`default_nettype none
module isa_window_dma_address_map_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                        clock = 1'b0;
  logic                        sys_rst = 1'b1;
  logic                        bus_grant_acknowledge = 1'b0;
  isa_window_pkg::mcu_req_t    req = '0;
  isa_window_pkg::page_map_t   pmap = '0;
  isa_window_pkg::isa_cycle_t  isa, seen;
  isa_window_pkg::buf_access_t buf_access, bseen;
  logic [7:0]                  mcu_rdata, isa_rdata, q, dma_command;
  logic                        mcu_rdata_valid, dma_ext_mem, dma_io_enable;
  logic                        byte_pointer, ext_seen, io_seen;
  logic                        dma_cycle = 1'b0;
  logic [1:0]                  dma_channel = 2'h0;
  logic [3:0]                  dma_channel_mask, dma_soft_request;
  int                          errors = 0, compares = 0, cycles = 0;
  logic [1:0]  tch [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3, 2'h0};
  logic [15:0] tad [7] = '{16'ha827, 16'ha827, 16'hfc00, 16'h8000,
                           16'h1234, 16'h7fff, 16'h0100};
  logic [4:0]  tpg [7] = '{5'h13, 5'h13, 5'h07, 5'h02, 5'h00, 5'h00, 5'h00};

  isa_window_dma_address_map dut (.clock(clock), .sys_rst(sys_rst),
    .mcu_req(req), .bus_grant_acknowledge(bus_grant_acknowledge),
    .mcu_rdata(mcu_rdata), .mcu_rdata_valid(mcu_rdata_valid),
    .isa_rdata(isa_rdata), .dreq_pin(4'h0), .isa(isa),
    .dma_cycle(dma_cycle), .dma_channel(dma_channel),
    .buf_access(buf_access), .dma_ext_mem(dma_ext_mem),
    .dma_io_enable(dma_io_enable), .dma_command(dma_command),
    .dma_channel_mask(dma_channel_mask),
    .dma_soft_request(dma_soft_request), .byte_pointer(byte_pointer),
    .page_map(pmap));
  isa_peripheral_model far (.clock(clock), .isa(isa), .isa_rdata(isa_rdata));

  always #25 clock = ~clock;

  task automatic tally_and_finish;
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One strobe cycle; the ISA cycle is caught in c1, the answer in c2.
  task automatic mcu(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    req = '{addr: a, wdata: d, rd: !wr, wr: wr};
    @(negedge clock);
    seen = isa;
    req.rd = 1'b0;
    req.wr = 1'b0;
    @(negedge clock);
    q = mcu_rdata;
    if (!wr)
      chk(20'(mcu_rdata_valid), 20'h1);
  endtask : mcu

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    mcu(1'b0, a, 8'h00);
    chk(20'(q), 20'(e));
  endtask : rd_chk

  task automatic set_reg(input logic [3:0] off, input logic [15:0] v);
    mcu(1'b1, 16'h400c, 8'h00);
    mcu(1'b1, {12'h400, off}, v[7:0]);
    mcu(1'b1, {12'h400, off}, v[15:8]);
  endtask : set_reg

  task automatic dma(input logic [1:0] ch);
    @(negedge clock);
    dma_cycle = 1'b1;
    dma_channel = ch;
    @(negedge clock);
    bseen = buf_access;
    ext_seen = dma_ext_mem;
    io_seen = dma_io_enable;
    seen = isa;
    dma_cycle = 1'b0;
  endtask : dma

  task automatic load_page(input logic [4:0] p, input logic [4:0] pg);
    @(negedge clock);
    pmap = '{packet: p, index: 4'h0, page: pg, wr: 1'b1};
    @(negedge clock);
    pmap.wr = 1'b0;
  endtask : load_page

  initial
  begin
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    chk(20'(dma_channel_mask), 20'hf);
    rd_chk(16'h7f71, 8'h00);
    rd_chk(16'h7f72, 8'h00);
    rd_chk(16'h3000, 8'h00);
    mcu(1'b1, 16'h7f71, 8'h12);
    mcu(1'b1, 16'h7f72, 8'hab);
    rd_chk(16'h7f72, 8'hab);
    mcu(1'b1, 16'h4077, 8'h3c);
    chk(seen.addr, 20'h01277);
    chk(20'(seen.iow), 20'h1);
    rd_chk(16'h4077, 8'h3c);
    mcu(1'b1, 16'h5123, 8'hc5);
    chk(seen.addr, 20'hab123);
    rd_chk(16'h5123, 8'hc5);
    chk(20'(seen.memr), 20'h1);
    mcu(1'b1, 16'h7f71, 8'h00);
    set_reg(4'h1, 16'hff10);
    chk(20'(byte_pointer), 20'h0);
    mcu(1'b1, 16'h400c, 8'h00);
    rd_chk(16'h4001, 8'h10);
    chk(20'(byte_pointer), 20'h1);
    rd_chk(16'h4001, 8'h03);
    mcu(1'b1, 16'h4008, 8'h5a);
    chk(20'(dma_command), 20'h5a);
    mcu(1'b1, 16'h400f, 8'h05);
    chk(20'(dma_channel_mask), 20'h5);
    mcu(1'b1, 16'h400e, 8'h00);
    chk(20'(dma_channel_mask), 20'h0);
    mcu(1'b1, 16'h400a, 8'h06);
    chk(20'(dma_channel_mask), 20'h4);
    mcu(1'b1, 16'h4009, 8'h07);
    chk(20'(dma_soft_request), 20'h8);
    mcu(1'b1, 16'h4000, 8'h11);
    mcu(1'b1, 16'h400d, 8'h00);
    chk({byte_pointer, dma_command, dma_channel_mask}, 20'h00f);
    bus_grant_acknowledge = 1'b1;
    mcu(1'b1, 16'h4008, 8'h33);
    chk(20'(dma_command), 20'h00);
    bus_grant_acknowledge = 1'b0;
    dma(2'h0);
    chk(20'({bseen.valid, ext_seen}), 20'h0);
    load_page(5'h0a, 5'h13);
    load_page(5'h1f, 5'h07);
    load_page(5'h00, 5'h02);
    // Each group's channels are loaded before any of its steps, so a shared
    // channel register would show up as a wrong packet, pointer or external address.
    for (int g = 0; g < 7; g += 4)
    begin
      bus_grant_acknowledge = 1'b0;
      for (int i = g; i < g + 4 && i < 7; i++)
        set_reg({1'b0, tch[i], 1'b0}, tad[i]);
      bus_grant_acknowledge = 1'b1;
      for (int i = g; i < g + 4 && i < 7; i++)
      begin
        dma(tch[i]);
        chk(20'(bseen.valid), 20'(tad[i][15]));
        chk(20'(ext_seen), 20'(!tad[i][15]));
        if (tad[i][15])
        begin
          chk(20'(bseen.packet), 20'(tad[i][14:10]));
          chk(20'(bseen.pointer), 20'(tad[i][9:0]));
          chk(20'(bseen.phys_addr), 20'({tpg[i], tad[i][6:0]}));
        end
        else
        begin
          chk(seen.addr, {5'h00, tad[i][14:0]});
          chk(20'(io_seen), 20'(tch[i][1]));
        end
      end
    end
    bus_grant_acknowledge = 1'b0;
    rd_chk(16'h4008, 8'h0e);
    rd_chk(16'h4008, 8'h00);
    set_reg(4'h3, 16'h0000);
    // A terminal count that lands on the status read itself must survive.
    bus_grant_acknowledge = 1'b1;
    @(negedge clock);
    req = '{addr: 16'h4008, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
    dma_cycle = 1'b1;
    dma_channel = 2'h1;
    @(negedge clock);
    req.rd = 1'b0;
    dma_cycle = 1'b0;
    bus_grant_acknowledge = 1'b0;
    rd_chk(16'h4008, 8'h02);
    rd_chk(16'h4008, 8'h00);
    tally_and_finish();
  end
endmodule : isa_window_dma_address_map_tb_top
`default_nettype wire
